// [logic/cilt_pkg.sv]
// Constants and operation codes for the instruction length and timing decoder
package cilt_pkg;
    localparam logic [1:0] LEN1 = 2'h1;
    localparam logic [1:0] LEN2 = 2'h2;
    localparam logic [1:0] LEN3 = 2'h3;
    localparam logic [3:0] CYC1 = 4'h1;
    localparam logic [3:0] CYC2 = 4'h2;
    localparam logic [3:0] CYC3 = 4'h3;
    localparam logic [3:0] CYC4 = 4'h4;
    localparam logic [3:0] CYC5 = 4'h5;
    localparam logic [3:0] CYC6 = 4'h6;
    // Prefetch refill stall on a taken branch, added in slow flash timing and again with prefetch disabled
    localparam logic [3:0] BRANCH_EXTRA_CYC = 4'h2;
    localparam logic [7:0] BANK_RES_HI = 8'h00;
    typedef enum logic [5:0] {
        OP_NOP, OP_LOAD_DP_IMM, OP_CODE_RD_DP, OP_CODE_RD_PC,
        OP_XD_RD_PTR, OP_XD_WR_PTR, OP_XD_RD_DP, OP_XD_WR_DP,
        OP_PUSH, OP_POP, OP_XCH_BANK, OP_XCH_DIR, OP_XCH_IND,
        OP_NIBBLE_SWAP, OP_MOV_DIR_DIR, OP_MOV_IND_A, OP_MOV_DIR_IMM,
        OP_MOV_IND_IMM, OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT,
        OP_OR_C_NBIT, OP_MOV_C_BIT, OP_MOV_BIT_C,
        OP_JMP_C, OP_JMP_NC, OP_JMP_Z, OP_JMP_NZ,
        OP_JMP_BIT, OP_JMP_NBIT, OP_BIT_TEST_JUMP_CLEAR,
        OP_ABSOLUTE_CALL, OP_ABSOLUTE_JUMP, OP_LONG_CALL, OP_LONG_JUMP,
        OP_SUB_RETURN, OP_INTERRUPT_RETURN, OP_SHORT_JUMP, OP_JMP_IND_DP,
        OP_CMP_A_DIR, OP_CMP_IND_IMM, OP_CMP_A_IMM, OP_CMP_BANK_IMM,
        OP_DEC_JMP_BANK, OP_DEC_JMP_DIR
    } cilt_op_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } cilt_state_t;
endpackage : cilt_pkg

// [logic/cilt_decoder.sv]
// Instruction length and cycle timing decoder with execution cycle counter
`timescale 1ns/1ps
module cilt_decoder (
    input wire logic clk_in, // 125 MHz system clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic op_valid_in, // Operation offered
    input wire cilt_pkg::cilt_op_t op_in, // Operation code
    input wire logic taken_in, // Branch condition resolved true
    input wire logic flash_read_timing_sel_in, // Slow flash timing
    input wire logic code_prefetch_unit_en_in, // Prefetch enabled
    input wire logic [15:0] pc_in, // Address of first code byte
    input wire logic [7:0] rel_in, // Signed relative offset
    input wire logic [1:0] bank_sel_in, // Selected register bank
    input wire logic ptr_sel_in, // Pointer register zero or one
    output logic ready_out, // Can take an operation
    output logic busy_out, // Executing
    output logic done_out, // Last execution cycle
    output logic [1:0] len_out, // Code bytes fetched
    output logic [3:0] cycles_out, // Cycles spent
    output logic [15:0] target_out, // Relative branch target
    output logic [7:0] ptr_addr_out // Indirect pointer register address
);
    logic rst_meta;
    logic rst_n;
    cilt_pkg::cilt_state_t state;
    cilt_pkg::cilt_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [1:0] next_len_out;
    logic [3:0] next_cycles_out;
    logic [15:0] next_target_out;
    logic [7:0] next_ptr_addr_out;
    logic [1:0] d_len;
    logic [3:0] d_nt;
    logic [3:0] d_tk;
    logic d_flow;
    logic d_cond;
    logic eff_taken;
    logic accept;
    logic [3:0] total;
    logic [15:0] next_pc;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        d_len = cilt_pkg::LEN1;
        d_nt = cilt_pkg::CYC1;
        d_tk = cilt_pkg::CYC1;
        d_flow = 1'b0;
        d_cond = 1'b0;
        case (op_in)
            cilt_pkg::OP_LOAD_DP_IMM, cilt_pkg::OP_MOV_DIR_DIR,
            cilt_pkg::OP_MOV_DIR_IMM: begin
                d_len = cilt_pkg::LEN3;
                d_nt = cilt_pkg::CYC3;
            end
            cilt_pkg::OP_CODE_RD_DP, cilt_pkg::OP_CODE_RD_PC,
            cilt_pkg::OP_XD_RD_PTR, cilt_pkg::OP_XD_WR_PTR,
            cilt_pkg::OP_XD_RD_DP, cilt_pkg::OP_XD_WR_DP: begin
                d_nt = cilt_pkg::CYC3;
            end
            cilt_pkg::OP_PUSH, cilt_pkg::OP_POP, cilt_pkg::OP_XCH_DIR,
            cilt_pkg::OP_MOV_IND_IMM, cilt_pkg::OP_AND_C_BIT,
            cilt_pkg::OP_AND_C_NBIT, cilt_pkg::OP_OR_C_BIT,
            cilt_pkg::OP_OR_C_NBIT, cilt_pkg::OP_MOV_C_BIT,
            cilt_pkg::OP_MOV_BIT_C: begin
                d_len = cilt_pkg::LEN2;
                d_nt = cilt_pkg::CYC2;
            end
            cilt_pkg::OP_XCH_IND, cilt_pkg::OP_NIBBLE_SWAP,
            cilt_pkg::OP_MOV_IND_A: begin
                d_nt = cilt_pkg::CYC2;
            end
            cilt_pkg::OP_JMP_C, cilt_pkg::OP_JMP_NC, cilt_pkg::OP_JMP_Z,
            cilt_pkg::OP_JMP_NZ, cilt_pkg::OP_DEC_JMP_BANK: begin
                d_len = cilt_pkg::LEN2;
                d_nt = cilt_pkg::CYC2;
                d_tk = cilt_pkg::CYC4;
                d_flow = 1'b1;
                d_cond = 1'b1;
            end
            cilt_pkg::OP_JMP_BIT, cilt_pkg::OP_JMP_NBIT,
            cilt_pkg::OP_BIT_TEST_JUMP_CLEAR, cilt_pkg::OP_CMP_A_IMM,
            cilt_pkg::OP_CMP_BANK_IMM, cilt_pkg::OP_DEC_JMP_DIR: begin
                d_len = cilt_pkg::LEN3;
                d_nt = cilt_pkg::CYC3;
                d_tk = cilt_pkg::CYC5;
                d_flow = 1'b1;
                d_cond = 1'b1;
            end
            cilt_pkg::OP_CMP_A_DIR, cilt_pkg::OP_CMP_IND_IMM: begin
                d_len = cilt_pkg::LEN3;
                d_nt = cilt_pkg::CYC4;
                d_tk = cilt_pkg::CYC6;
                d_flow = 1'b1;
                d_cond = 1'b1;
            end
            cilt_pkg::OP_ABSOLUTE_CALL, cilt_pkg::OP_ABSOLUTE_JUMP,
            cilt_pkg::OP_SHORT_JUMP: begin
                d_len = cilt_pkg::LEN2;
                d_nt = cilt_pkg::CYC4;
                d_flow = 1'b1;
            end
            cilt_pkg::OP_JMP_IND_DP: begin
                d_nt = cilt_pkg::CYC4;
                d_flow = 1'b1;
            end
            cilt_pkg::OP_LONG_CALL, cilt_pkg::OP_LONG_JUMP: begin
                d_len = cilt_pkg::LEN3;
                d_nt = cilt_pkg::CYC5;
                d_flow = 1'b1;
            end
            cilt_pkg::OP_SUB_RETURN, cilt_pkg::OP_INTERRUPT_RETURN: begin
                d_nt = cilt_pkg::CYC6;
                d_flow = 1'b1;
            end
            default: begin
                d_len = cilt_pkg::LEN1;
            end
        endcase
        if (!d_cond) begin
            d_tk = d_nt;
        end
    end

    // Unconditional flow changes always redirect the fetch
    assign eff_taken = d_cond ? taken_in : d_flow;
    assign accept = op_valid_in && (state == cilt_pkg::ST_IDLE);
    assign ready_out = (state == cilt_pkg::ST_IDLE);
    assign busy_out = (state == cilt_pkg::ST_RUN);
    assign done_out = busy_out && (cnt == 4'h0);
    assign next_pc = pc_in + {14'h0000, d_len};

    always_comb begin
        total = eff_taken ? d_tk : d_nt;
        // Each slow-fetch cause costs one refill on a redirect
        if (d_flow && eff_taken && flash_read_timing_sel_in) begin
            total = total + cilt_pkg::BRANCH_EXTRA_CYC;
        end
        if (d_flow && eff_taken && !code_prefetch_unit_en_in) begin
            total = total + cilt_pkg::BRANCH_EXTRA_CYC;
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_len_out = len_out;
        next_cycles_out = cycles_out;
        next_target_out = target_out;
        next_ptr_addr_out = ptr_addr_out;
        case (state)
            cilt_pkg::ST_IDLE: begin
                if (accept) begin
                    next_state = cilt_pkg::ST_RUN;
                    next_cnt = total - 4'h1;
                    next_len_out = d_len;
                    next_cycles_out = total;
                    next_target_out = next_pc
                        + {{8{rel_in[7]}}, rel_in};
                    next_ptr_addr_out = {cilt_pkg::BANK_RES_HI[2:0],
                        bank_sel_in, 2'h0, ptr_sel_in};
                end
            end
            cilt_pkg::ST_RUN: begin
                if (cnt == 4'h0) begin
                    next_state = cilt_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = cilt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= cilt_pkg::ST_IDLE;
            cnt <= 4'h0;
            len_out <= 2'h0;
            cycles_out <= 4'h0;
            target_out <= 16'h0000;
            ptr_addr_out <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            len_out <= next_len_out;
            cycles_out <= next_cycles_out;
            target_out <= next_target_out;
            ptr_addr_out <= next_ptr_addr_out;
        end
    end

    chk_load_dp_timing: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_LOAD_DP_IMM
        |-> ##3 done_out ##1 len_out == 2'h3)
        else $error("data pointer load timing wrong");
    chk_code_read: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && (op_in == cilt_pkg::OP_CODE_RD_DP ||
        op_in == cilt_pkg::OP_CODE_RD_PC)
        |=> len_out == 2'h1 && cycles_out == 4'h3)
        else $error("code byte read timing wrong");
    chk_xdata_ptr: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_XD_WR_PTR
        |=> !done_out [*2] ##1 done_out)
        else $error("external pointer move timing wrong");
    chk_xdata_dp: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_XD_RD_DP
        |=> cycles_out == 4'h3 && len_out == 2'h1)
        else $error("external dp move timing wrong");
    chk_stack_ops: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && (op_in == cilt_pkg::OP_PUSH || op_in == cilt_pkg::OP_POP)
        |-> ##2 done_out ##1 ready_out)
        else $error("stack operation timing wrong");
    chk_swap_bank: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_XCH_BANK |=> done_out)
        else $error("bank swap timing wrong");
    chk_nibble_swap: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_NIBBLE_SWAP
        |=> cycles_out == 4'h2 && len_out == 2'h1)
        else $error("nibble swap timing wrong");
    chk_dir_copy: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_MOV_DIR_DIR
        |=> len_out == 2'h3 && cycles_out == 4'h3)
        else $error("direct byte copy timing wrong");
    chk_store_ind: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_MOV_IND_A
        |=> len_out == 2'h1 && !done_out ##1 done_out)
        else $error("indirect store timing wrong");
    chk_carry_logic: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in inside {cilt_pkg::OP_AND_C_NBIT,
        cilt_pkg::OP_OR_C_BIT} |=> len_out == 2'h2 && cycles_out == 4'h2)
        else $error("carry logic timing wrong");
    chk_carry_move: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_MOV_BIT_C
        |=> len_out == 2'h2 ##1 done_out)
        else $error("carry move timing wrong");
    // Taken flag is judged as it stood at the accept edge
    chk_branch_taken: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_JMP_C && code_prefetch_unit_en_in &&
        !flash_read_timing_sel_in
        |=> cycles_out == ($past(taken_in) ? 4'h4 : 4'h2))
        else $error("carry jump count wrong");
    chk_bit_jump: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_BIT_TEST_JUMP_CLEAR &&
        code_prefetch_unit_en_in && !flash_read_timing_sel_in
        |=> cycles_out == ($past(taken_in) ? 4'h5 : 4'h3))
        else $error("bit test jump count wrong");
    chk_compare_jump: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_CMP_IND_IMM &&
        code_prefetch_unit_en_in && !flash_read_timing_sel_in
        |=> cycles_out == ($past(taken_in) ? 4'h6 : 4'h4))
        else $error("compare jump count wrong");
    chk_branch_extra: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_SHORT_JUMP &&
        code_prefetch_unit_en_in && flash_read_timing_sel_in
        |=> cycles_out == 4'h6)
        else $error("slow flash branch penalty missing");
    // Only the fast-fetch figure; penalties lengthen returns too
    chk_return_run: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_INTERRUPT_RETURN &&
        code_prefetch_unit_en_in && !flash_read_timing_sel_in
        |=> busy_out [*6] ##1 ready_out)
        else $error("return timing wrong");
    chk_rel_target: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept && op_in == cilt_pkg::OP_SHORT_JUMP
        |=> target_out == $past(pc_in) + 16'h0002 +
        {{8{$past(rel_in[7])}}, $past(rel_in)})
        else $error("relative target wrong");
    chk_ptr_addr: assert property (
        @(posedge clk_in) disable iff (!rst_n)
        accept |=> ptr_addr_out[7:5] == 3'h0 &&
        ptr_addr_out[4:3] == $past(bank_sel_in) &&
        ptr_addr_out[0] == $past(ptr_sel_in))
        else $error("pointer register address wrong");
endmodule : cilt_decoder

// [dv/cilt_decoder_test.sv]
// Self-checking testbench for the instruction length and timing decoder
`timescale 1ns/1ps
module cilt_decoder_test;
    logic clk_in, resetn_in, op_valid_in, taken_in, ptr_sel_in;
    logic flash_read_timing_sel_in, code_prefetch_unit_en_in;
    cilt_pkg::cilt_op_t op_in;
    logic [15:0] pc_in;
    logic [7:0] rel_in;
    logic [1:0] bank_sel_in;
    logic ready_out, busy_out, done_out;
    logic [1:0] len_out;
    logic [3:0] cycles_out;
    logic [15:0] target_out;
    logic [7:0] ptr_addr_out;
    int error_cnt = 0;
    int checks_done = 0;

    cilt_decoder u_dut (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .op_valid_in(op_valid_in),
        .op_in(op_in),
        .taken_in(taken_in),
        .flash_read_timing_sel_in(flash_read_timing_sel_in),
        .code_prefetch_unit_en_in(code_prefetch_unit_en_in),
        .pc_in(pc_in),
        .rel_in(rel_in),
        .bank_sel_in(bank_sel_in),
        .ptr_sel_in(ptr_sel_in),
        .ready_out(ready_out),
        .busy_out(busy_out),
        .done_out(done_out),
        .len_out(len_out),
        .cycles_out(cycles_out),
        .target_out(target_out),
        .ptr_addr_out(ptr_addr_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Index follows the declared order of the operation enum: {len, lo, hi}
    function automatic logic [9:0] exp_info(input int i);
        case (i)
            1, 14, 16: return {2'h3, 4'h3, 4'h3};
            2, 3, 4, 5, 6, 7: return {2'h1, 4'h3, 4'h3};
            8, 9, 11, 17, 18, 19, 20, 21, 22, 23: return {2'h2, 4'h2, 4'h2};
            12, 13, 15: return {2'h1, 4'h2, 4'h2};
            24, 25, 26, 27, 43: return {2'h2, 4'h2, 4'h4};
            28, 29, 30, 41, 42, 44: return {2'h3, 4'h3, 4'h5};
            31, 32, 37: return {2'h2, 4'h4, 4'h4};
            33, 34: return {2'h3, 4'h5, 4'h5};
            35, 36: return {2'h1, 4'h6, 4'h6};
            38: return {2'h1, 4'h4, 4'h4};
            39, 40: return {2'h3, 4'h4, 4'h6};
            default: return {2'h1, 4'h1, 4'h1};
        endcase
    endfunction : exp_info

    // Entered at a falling edge with the decoder ready; returns done cycle
    task automatic run_op(input int i, input logic tk, input logic sel,
                          input logic pf, output int n);
        op_valid_in = 1'b1;
        op_in = cilt_pkg::cilt_op_t'(i);
        taken_in = tk;
        flash_read_timing_sel_in = sel;
        code_prefetch_unit_en_in = pf;
        @(posedge clk_in);
        @(negedge clk_in);
        op_valid_in = 1'b0;
        check(16'(busy_out), 16'h0001);
        check(16'(ready_out), 16'h0000);
        n = 1;
        while (done_out !== 1'b1 && n < 12) begin
            @(negedge clk_in);
            n++;
        end
        @(negedge clk_in);
        check(16'(ready_out), 16'h0001);
        check(16'(busy_out), 16'h0000);
        check(16'(done_out), 16'h0000);
    endtask : run_op

    // Runs a span of operations back to back and judges every answer
    task automatic run_range(input int lo, input int hi, input logic tk,
                             input logic sel, input logic pf);
        logic [9:0] e;
        logic [3:0] ec;
        int n;
        for (int i = lo; i <= hi; i++) begin
            e = exp_info(i);
            ec = e[7:4];
            if (i >= 24 && (tk || e[7:4] == e[3:0])) begin
                ec = e[3:0] + (sel ? 4'h2 : 4'h0) + (pf ? 4'h0 : 4'h2);
            end
            run_op(i, tk, sel, pf, n);
            check(16'(len_out), 16'(e[9:8]));
            check(16'(cycles_out), 16'(ec));
            check(16'(n), 16'(ec));
        end
    endtask : run_range

    // Penalty inputs present but must not lengthen data transfers
    task automatic test_transfer();
        run_range(0, 17, 1'b1, 1'b1, 1'b0);
    endtask : test_transfer

    task automatic test_bits();
        run_range(18, 23, 1'b1, 1'b1, 1'b0);
    endtask : test_bits

    task automatic test_branches();
        run_range(24, 44, 1'b0, 1'b0, 1'b1);
        run_range(24, 44, 1'b1, 1'b0, 1'b1);
    endtask : test_branches

    task automatic test_penalty();
        run_range(24, 44, 1'b1, 1'b1, 1'b1);
        run_range(24, 44, 1'b1, 1'b1, 1'b0);
        run_range(24, 44, 1'b1, 1'b0, 1'b0);
        run_range(24, 30, 1'b0, 1'b1, 1'b0);
    endtask : test_penalty

    // Offsets at both signed extremes, with a wrap past the top of memory
    task automatic test_target();
        int n;
        pc_in = 16'hfff0;
        rel_in = 8'h7f;
        run_op(37, 1'b1, 1'b0, 1'b1, n);
        check(target_out, 16'h0071);
        pc_in = 16'h0040;
        rel_in = 8'h80;
        run_op(28, 1'b0, 1'b0, 1'b1, n);
        check(target_out, 16'hffc3);
    endtask : test_target

    task automatic test_pointer();
        int n;
        for (int b = 0; b < 4; b++) begin
            for (int p = 0; p < 2; p++) begin
                bank_sel_in = 2'(b);
                ptr_sel_in = 1'(p);
                run_op(12, 1'b0, 1'b0, 1'b1, n);
                check(16'(ptr_addr_out),
                      {8'h00, 3'h0, 2'(b), 2'h0, 1'(p)});
            end
        end
    endtask : test_pointer

    // Reset in mid-operation abandons it and clears every output except ready_out, which rises
    task automatic test_reset();
        int n;
        op_valid_in = 1'b1;
        op_in = cilt_pkg::OP_INTERRUPT_RETURN;
        @(negedge clk_in);
        op_valid_in = 1'b0;
        resetn_in = 1'b0;
        @(negedge clk_in);
        check(16'(busy_out), 16'h0000);
        check(16'(ready_out), 16'h0001);
        check(16'(done_out), 16'h0000);
        check(16'(len_out), 16'h0000);
        check(16'(cycles_out), 16'h0000);
        check(target_out, 16'h0000);
        check(16'(ptr_addr_out), 16'h0000);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        run_op(36, 1'b0, 1'b0, 1'b1, n);
        check(16'(n), 16'h0006);
        check(16'(cycles_out), 16'h0006);
    endtask : test_reset

    initial begin
        resetn_in = 1'b0;
        op_valid_in = 1'b0;
        op_in = cilt_pkg::OP_NOP;
        taken_in = 1'b0;
        flash_read_timing_sel_in = 1'b0;
        code_prefetch_unit_en_in = 1'b1;
        pc_in = 16'h0000;
        rel_in = 8'h00;
        bank_sel_in = 2'h0;
        ptr_sel_in = 1'b0;
        repeat (16) @(negedge clk_in);
        resetn_in = 1'b1;
        // Internal reset copy lags by two edges
        repeat (3) @(negedge clk_in);
        test_transfer();
        test_bits();
        test_branches();
        test_penalty();
        test_target();
        test_pointer();
        test_reset();
        print_verdict();
    end

    // About 900 cycles expected; generous margin before giving up
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        print_verdict();
    end
endmodule : cilt_decoder_test
